// file: shared/wdtc_pkg.sv
package wdtc_pkg;
	// Register indexes on the plain register port
	localparam logic [1:0] ADDR_CTRL = 2'h0;
	localparam logic [1:0] ADDR_COUNT = 2'h1;
	localparam logic [1:0] ADDR_ISTAT = 2'h2;
	localparam logic [1:0] ADDR_IMASK = 2'h3;
	// Field positions of timer_ctrl_status
	localparam int BIT_OVF = 7;
	localparam int BIT_MODE = 6;
	localparam int BIT_EN = 5;
	localparam int BIT_CKS_HI = 2;
	// Reset value: reserved bits 4 and 3 read as one
	localparam logic [7:0] CTRL_RESET = 8'h18;
	localparam logic [7:0] CTRL_FIXED_ONES = 8'h18;
	// Upper bytes that unlock a write (arbitrary values)
	localparam logic [7:0] PASS_CTRL = 8'hA5;
	localparam logic [7:0] PASS_COUNT = 8'h5A;
	// Interrupt status bits
	localparam int IST_WIDTH = 3;
	localparam int IST_INTERVAL = 0;
	localparam int IST_WATCHDOG = 1;
	localparam int IST_BADPASS = 2;
	// Watchdog overflow output pulse length in clock cycles
	localparam logic [2:0] WDO_CYCLES = 3'h4;
	// Prescaler width; clock select n divides by 2^(2n+1)
	localparam int PRESC_WIDTH = 16;
endpackage

// file: verilog/wdtc_top.sv
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Contract
// - An 8-bit control/status register selects count clock and timer mode.
// - Reset and hardware standby load the register with H'18.
// - Software standby leaves the register contents unchanged.
// - Interval mode sets bit 7 overflow flag when counter wraps FF to 00.
// - Watchdog mode never sets the overflow flag.
// - Flag clears only by a read seeing one, then writing zero.
// - Writing one to the flag leaves it unchanged.
// - In interval mode each overflow raises the interval interrupt request.
// - In watchdog mode each overflow drives the watchdog overflow output.
// - Control and counter writes without the correct password are ignored.
module wdtc_top (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic [1:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic sw_standby_i,
	input wire logic hw_standby_i,
	output logic [7:0] rdata_o,
	output logic interval_interrupt_request_o,
	output logic watchdog_overflow_output_o,
	output logic irq_o
);

	typedef struct packed {
		logic overflow_flag;
		logic timer_mode_select;
		logic timer_enable_bit;
		logic [2:0] clock_select;
		logic [7:0] count_register;
		logic [wdtc_pkg::PRESC_WIDTH-1:0] presc;
		logic clear_armed;
		logic [2:0] wdo_left;
		logic wdo;
		logic [wdtc_pkg::IST_WIDTH-1:0] istat;
		logic [wdtc_pkg::IST_WIDTH-1:0] imask;
		logic [7:0] rdata;
		logic irq;
	} wdtc_state_type;

	wdtc_state_type state;
	wdtc_state_type next_state;

	logic [7:0] ctrl_view;
	logic [wdtc_pkg::PRESC_WIDTH-1:0] tick_mask;
	logic tick;
	logic wrap;
	logic ctrl_wr;
	logic ctrl_wr_ok;
	logic count_wr_ok;

	// Assembled register image; reserved bits always read as one
	always_comb begin
		ctrl_view = wdtc_pkg::CTRL_FIXED_ONES;
		ctrl_view[wdtc_pkg::BIT_OVF] = state.overflow_flag;
		ctrl_view[wdtc_pkg::BIT_MODE] = state.timer_mode_select;
		ctrl_view[wdtc_pkg::BIT_EN] = state.timer_enable_bit;
		ctrl_view[wdtc_pkg::BIT_CKS_HI:0] = state.clock_select;
	end

	// Count tick: prescaler low bits all ones for the selected divide ratio
	always_comb begin
		tick_mask = '0;
		for (int i = 0; i < wdtc_pkg::PRESC_WIDTH; i++) begin
			if (i <= 2 * int'(state.clock_select)) begin
				tick_mask[i] = 1'b1;
			end
		end
		tick = ((state.presc & tick_mask) == tick_mask) && !sw_standby_i;
		wrap = tick && state.timer_enable_bit && (state.count_register == 8'hFF);
	end

	// Password check on the upper byte of each control and counter write
	assign ctrl_wr = wr_i && (addr_i == wdtc_pkg::ADDR_CTRL);
	assign ctrl_wr_ok = ctrl_wr && (wdata_i[15:8] == wdtc_pkg::PASS_CTRL);
	assign count_wr_ok = wr_i && (addr_i == wdtc_pkg::ADDR_COUNT) &&
		(wdata_i[15:8] == wdtc_pkg::PASS_COUNT);

	// Next state of the whole block
	always_comb begin
		next_state = state;
		next_state.rdata = 8'h00;

		// Prescaler runs freely outside software standby
		if (!sw_standby_i) begin
			next_state.presc = state.presc + {{(wdtc_pkg::PRESC_WIDTH-1){1'b0}}, 1'b1};
		end

		// Counter only advances while enabled; disabled holds it at zero
		if (!state.timer_enable_bit) begin
			next_state.count_register = 8'h00;
		end else if (tick) begin
			next_state.count_register = state.count_register + 8'h01;
		end

		// Watchdog pulse countdown
		if (state.wdo_left != 3'h0) begin
			next_state.wdo_left = state.wdo_left - 3'h1;
		end

		// Register reads; a read that sees the flag set arms the clear
		if (rd_i) begin
			case (addr_i)
				wdtc_pkg::ADDR_CTRL: begin
					next_state.rdata = ctrl_view;
					if (state.overflow_flag) begin
						next_state.clear_armed = 1'b1;
					end
				end
				wdtc_pkg::ADDR_COUNT: begin
					next_state.rdata = state.count_register;
				end
				wdtc_pkg::ADDR_ISTAT: begin
					next_state.rdata = {5'h00, state.istat};
				end
				wdtc_pkg::ADDR_IMASK: begin
					next_state.rdata = {5'h00, state.imask};
				end
				default: begin
					next_state.rdata = 8'h00;
				end
			endcase
		end

		// Software standby freezes the register against writes as well
		if (wr_i && !sw_standby_i) begin
			case (addr_i)
				wdtc_pkg::ADDR_CTRL: begin
					if (ctrl_wr_ok) begin
						next_state.timer_mode_select = wdata_i[wdtc_pkg::BIT_MODE];
						next_state.timer_enable_bit = wdata_i[wdtc_pkg::BIT_EN];
						next_state.clock_select = wdata_i[wdtc_pkg::BIT_CKS_HI:0];
						// Zero clears only after an arming read; one is ignored
						if (!wdata_i[wdtc_pkg::BIT_OVF] && state.clear_armed) begin
							next_state.overflow_flag = 1'b0;
						end
						next_state.clear_armed = 1'b0;
					end else begin
						next_state.istat[wdtc_pkg::IST_BADPASS] = 1'b1;
					end
				end
				wdtc_pkg::ADDR_COUNT: begin
					if (count_wr_ok) begin
						next_state.count_register = wdata_i[7:0];
					end else begin
						next_state.istat[wdtc_pkg::IST_BADPASS] = 1'b1;
					end
				end
				wdtc_pkg::ADDR_ISTAT: begin
					// Write one to clear; events below override the clear
					next_state.istat = state.istat & ~wdata_i[wdtc_pkg::IST_WIDTH-1:0];
				end
				wdtc_pkg::ADDR_IMASK: begin
					next_state.imask = wdata_i[wdtc_pkg::IST_WIDTH-1:0];
				end
				default: begin
					next_state.imask = state.imask;
				end
			endcase
		end

		// Overflow handling placed after the register writes so a set wins over a same-cycle clear
		if (wrap) begin
			if (!state.timer_mode_select) begin
				next_state.overflow_flag = 1'b1;
				next_state.istat[wdtc_pkg::IST_INTERVAL] = 1'b1;
			end else begin
				next_state.wdo_left = wdtc_pkg::WDO_CYCLES - 3'h1;
				next_state.istat[wdtc_pkg::IST_WATCHDOG] = 1'b1;
			end
		end
		next_state.wdo = wrap ? state.timer_mode_select : (state.wdo_left != 3'h0);

		// Hardware standby reinitialises the timer fields like a reset; event status, mask and read data are kept
		if (hw_standby_i) begin
			next_state.overflow_flag = 1'b0;
			next_state.timer_mode_select = 1'b0;
			next_state.timer_enable_bit = 1'b0;
			next_state.clock_select = 3'h0;
			next_state.count_register = 8'h00;
			next_state.presc = '0;
			next_state.clear_armed = 1'b0;
			next_state.wdo_left = 3'h0;
			next_state.wdo = 1'b0;
		end

		next_state.irq = |(next_state.istat & next_state.imask);
	end

	// State register; reset value of the control fields follows H'18
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign rdata_o = state.rdata;
	assign interval_interrupt_request_o = state.overflow_flag;
	assign watchdog_overflow_output_o = state.wdo;
	assign irq_o = state.irq;

	// Hardware standby leaves the register at its reset image
	chk_hw_standby_init: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		hw_standby_i |=> (ctrl_view == wdtc_pkg::CTRL_RESET))
		else $error("control register not H'18 after hardware standby");

	// Software standby keeps control contents
	chk_sw_standby_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(sw_standby_i && !hw_standby_i) |=> $stable(ctrl_view))
		else $error("control register changed in software standby");

	// Interval wrap sets the flag on the next edge
	chk_interval_ovf_set: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(wrap && !state.timer_mode_select && !hw_standby_i) |=> state.overflow_flag)
		else $error("overflow flag not set on interval wrap");

	// Flag may only rise from an interval wrap
	chk_watchdog_no_ovf: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(state.overflow_flag) |-> ($past(wrap) && !$past(state.timer_mode_select)))
		else $error("overflow flag set without interval wrap");

	// A fall of the flag needs an arming read and a zero write
	chk_clear_sequence: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		($fell(state.overflow_flag) && !$past(hw_standby_i)) |->
			($past(state.clear_armed) && $past(ctrl_wr_ok) && !$past(wdata_i[7])))
		else $error("overflow flag cleared without read then zero write");

	// Writing one never clears the flag
	chk_write_one_keeps: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(state.overflow_flag && ctrl_wr_ok && wdata_i[7] && !hw_standby_i) |=> state.overflow_flag)
		else $error("writing one changed the overflow flag");

	// Interval request follows each interval wrap
	chk_interval_request: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(wrap && !state.timer_mode_select && !hw_standby_i) |=> interval_interrupt_request_o)
		else $error("interval request missing after wrap");

	// Watchdog wrap gives a pulse of exactly four cycles
	chk_watchdog_pulse: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(wrap && state.timer_mode_select && !hw_standby_i)
			|=> ((!$rose(interval_interrupt_request_o) && watchdog_overflow_output_o) ##0
			watchdog_overflow_output_o[*4] ##1 !watchdog_overflow_output_o))
		else $error("watchdog overflow pulse wrong");

	// Bad password leaves mode, enable and clock select untouched
	chk_password_guard: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(ctrl_wr && !ctrl_wr_ok && !sw_standby_i && !hw_standby_i) |=> ($stable(ctrl_view[6:0]) && state.istat[2]))
		else $error("control register changed by write without password");

	// Enabled counter advances by one on a tick
	chk_count_advance: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(tick && state.timer_enable_bit && !wr_i && !hw_standby_i) |=>
			(state.count_register == $past(state.count_register) + 8'h01))
		else $error("counter did not advance on tick");

	// Disabled counter sits at zero
	chk_count_disabled: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(!state.timer_enable_bit && !count_wr_ok) |=> (state.count_register == 8'h00))
		else $error("counter moved while disabled");

	// Password placed in upper byte only
	chk_password_byte: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(ctrl_wr && (wdata_i[15:8] == wdtc_pkg::PASS_CTRL) && !sw_standby_i && !hw_standby_i)
			|=> (state.clock_select == $past(wdata_i[2:0])))
		else $error("password write did not load low byte");

	// Read data stands only in the cycle after the read
	chk_read_timing: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(!rd_i) |=> (rdata_o == 8'h00))
		else $error("read data outside the answer cycle");

	// Interval wrap is also logged as a sticky event
	chk_interval_event: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(wrap && !state.timer_mode_select && !hw_standby_i) |=> state.istat[wdtc_pkg::IST_INTERVAL])
		else $error("interval event bit not set on wrap");

	// Watchdog wrap is logged as a sticky event
	chk_watchdog_event: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(wrap && state.timer_mode_select && !hw_standby_i) |=> state.istat[wdtc_pkg::IST_WATCHDOG])
		else $error("watchdog event bit not set on wrap");

	// A read that sees the flag set arms the clear
	chk_clear_arming: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(rd_i && (addr_i == wdtc_pkg::ADDR_CTRL) && state.overflow_flag && !wr_i && !hw_standby_i) |=> state.clear_armed)
		else $error("flag read did not arm the clear");

	// Any accepted control write uses up the arming read
	chk_clear_disarm: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(ctrl_wr_ok && !sw_standby_i && !hw_standby_i) |=> !state.clear_armed)
		else $error("clear still armed after control write");

	// Counter write with its password loads the low byte
	chk_count_load: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		(count_wr_ok && state.timer_enable_bit && !sw_standby_i && !hw_standby_i)
			|=> (state.count_register == $past(wdata_i[7:0])))
		else $error("counter write did not load low byte");

endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic core_clk_i, rstn_i, wr_i, rd_i, sw_standby_i, hw_standby_i;
	logic [1:0] addr_i;
	logic [15:0] wdata_i;
	logic [7:0] rdata_o, v;
	logic interval_interrupt_request_o, watchdog_overflow_output_o, irq_o;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;
	int k;

	wdtc_top wdtc_top_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .sw_standby_i(sw_standby_i), .hw_standby_i(hw_standby_i),
		.rdata_o(rdata_o), .interval_interrupt_request_o(interval_interrupt_request_o),
		.watchdog_overflow_output_o(watchdog_overflow_output_o), .irq_o(irq_o));

	// Free-running 100 MHz clock
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	// Hang guard: the whole run needs a few hundred cycles at most
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One-cycle strobes, launched just after an edge and dropped after the sampling edge
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [1:0] a, output logic [7:0] r);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1 r = rdata_o;
	endtask

	// Wrong password is dropped and reported through the masked interrupt
	task automatic t_password();
		wr(wdtc_pkg::ADDR_IMASK, 16'h0004);
		wr(wdtc_pkg::ADDR_CTRL, 16'h1227);
		rd(wdtc_pkg::ADDR_CTRL, v);
		chk("ctrl after bad password", v, 8'h18);
		chk("irq bad password", {7'h00, irq_o}, 8'h01);
		wr(wdtc_pkg::ADDR_ISTAT, 16'h0004);
		repeat (2) @(posedge core_clk_i);
		#1 chk("irq cleared", {7'h00, irq_o}, 8'h00);
	endtask

	// Interval wrap sets the flag; the flag needs an arming read and a zero write
	task automatic t_interval();
		// Enable first: a disabled counter is held at zero and would lose the load
		wr(wdtc_pkg::ADDR_CTRL, 16'hA520);
		wr(wdtc_pkg::ADDR_COUNT, 16'h5AFF);
		for (k = 0; k < 20 && interval_interrupt_request_o !== 1'b1; k++) begin
			@(posedge core_clk_i);
			#1;
		end
		chk("interval request", {7'h00, interval_interrupt_request_o}, 8'h01);
		wr(wdtc_pkg::ADDR_CTRL, 16'hA520);
		rd(wdtc_pkg::ADDR_CTRL, v);
		chk("flag kept without read", v, 8'hB8);
		wr(wdtc_pkg::ADDR_CTRL, 16'hA5A0);
		rd(wdtc_pkg::ADDR_CTRL, v);
		chk("flag kept on one", v, 8'hB8);
		rd(wdtc_pkg::ADDR_CTRL, v); // Polling reads the set flag twice before clearing
		wr(wdtc_pkg::ADDR_CTRL, 16'hA500);
		rd(wdtc_pkg::ADDR_CTRL, v);
		chk("flag cleared", v, 8'h18);
		chk("request dropped", {7'h00, interval_interrupt_request_o}, 8'h00);
		rd(wdtc_pkg::ADDR_COUNT, v);
		chk("count held when off", v, 8'h00);
	endtask

	// Watchdog wrap pulses the output and never touches the flag
	task automatic t_watchdog();
		wr(wdtc_pkg::ADDR_CTRL, 16'hA561);
		wr(wdtc_pkg::ADDR_COUNT, 16'h5AFF);
		// Sample just after each edge so the output has settled
		for (k = 0; k < 40 && watchdog_overflow_output_o !== 1'b1; k++) begin
			@(posedge core_clk_i);
			#1;
		end
		for (k = 0; k < 10 && watchdog_overflow_output_o === 1'b1; k++) begin
			@(posedge core_clk_i);
			#1;
		end
		chk("watchdog pulse cycles", k[7:0], {5'h00, wdtc_pkg::WDO_CYCLES});
		chk("no interval request", {7'h00, interval_interrupt_request_o}, 8'h00);
		rd(wdtc_pkg::ADDR_CTRL, v);
		chk("flag stays clear", v, 8'h79);
		rd(wdtc_pkg::ADDR_ISTAT, v);
		chk("event status", v, 8'h03);
		rd(wdtc_pkg::ADDR_IMASK, v);
		chk("event mask", v, 8'h04);
	endtask

	// Software standby keeps the register, hardware standby reloads it
	task automatic t_standby();
		@(posedge core_clk_i);
		sw_standby_i <= 1'b1;
		wr(wdtc_pkg::ADDR_CTRL, 16'hA502);
		rd(wdtc_pkg::ADDR_CTRL, v);
		chk("ctrl in sw standby", v, 8'h79);
		@(posedge core_clk_i);
		sw_standby_i <= 1'b0;
		hw_standby_i <= 1'b1;
		@(posedge core_clk_i);
		hw_standby_i <= 1'b0;
		rd(wdtc_pkg::ADDR_CTRL, v);
		chk("ctrl after hw standby", v, 8'h18);
	endtask

	initial begin
		rstn_i = 1'b0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		sw_standby_i = 1'b0;
		hw_standby_i = 1'b0;
		addr_i = 2'h0;
		wdata_i = 16'h0000;
		repeat (20) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		rd(wdtc_pkg::ADDR_CTRL, v);
		chk("ctrl reset", v, wdtc_pkg::CTRL_RESET);
		t_password();
		t_interval();
		t_watchdog();
		t_standby();
		give_verdict();
	end
endmodule
